//--- design/cmm_ctl.sv
// apb register block: mode control, mask select, overflow flags and interrupt
`timescale 1ns/10ps
`default_nettype none
module cmm_ctl
  import cmm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_idle,
  input wire logic abort_done,
  input wire logic mode_ack,
  input wire logic [2:0] mode_ack_code,
  input wire logic rx_msg_done,
  input wire cmm_rx_evt_t rx_evt,
  output cmm_core_ctl_t core_ctl,
  output logic [15:0] filter_mask_select,
  output logic rx_capture_event,
  output logic irq
);

  logic idle_stop;
  logic abort_all_tx;
  logic [2:0] requested_mode;
  logic [2:0] current_mode;
  logic rx_capture_enable;
  logic window_sel;
  logic [31:0] rx_overflow;
  logic [CMM_EV_COUNT-1:0] irq_status;
  logic [CMM_EV_COUNT-1:0] irq_mask;
  logic [CMM_EV_COUNT-1:0] ev_set;
  logic [31:0] ovf_set;
  logic [31:0] ovf_clr;
  logic [31:0] next_ovf;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic wr_en;
  logic wr_ctrl;
  logic wr_fmsk;
  logic wr_ovf_lo;
  logic wr_ovf_hi;
  logic wr_istat;
  logic wr_imask;
  logic req_code_ok;
  logic abort_finish;

  // address decode and write strobes, zero wait states
  always_comb begin
    addr_ok = (paddr == CMM_OFS_CTRL) || (paddr == CMM_OFS_FMSKSEL) ||
              (paddr == CMM_OFS_OVF_LOW) || (paddr == CMM_OFS_OVF_HIGH) ||
              (paddr == CMM_OFS_IRQ_STAT) || (paddr == CMM_OFS_IRQ_MASK);
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign wr_ctrl = wr_en & (paddr == CMM_OFS_CTRL);
  assign wr_fmsk = wr_en & (paddr == CMM_OFS_FMSKSEL);
  assign wr_ovf_lo = wr_en & (paddr == CMM_OFS_OVF_LOW);
  assign wr_ovf_hi = wr_en & (paddr == CMM_OFS_OVF_HIGH);
  assign wr_istat = wr_en & (paddr == CMM_OFS_IRQ_STAT);
  assign wr_imask = wr_en & (paddr == CMM_OFS_IRQ_MASK);

  // reserved mode codes are not accepted as requests
  assign req_code_ok = (pwdata[CMM_BIT_REQ_LSB +: 3] != CMM_MODE_RSVD_A) &&
                       (pwdata[CMM_BIT_REQ_LSB +: 3] != CMM_MODE_RSVD_B); // RULE4
  assign abort_finish = abort_all_tx & abort_done;

  // plain control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_stop <= 1'b0;
      rx_capture_enable <= 1'b0;
      window_sel <= 1'b0;
    end else if (wr_ctrl) begin
      idle_stop <= pwdata[CMM_BIT_IDLE_STOP]; // RULE1
      rx_capture_enable <= pwdata[CMM_BIT_CAPTURE]; // RULE7
      window_sel <= pwdata[CMM_BIT_WINDOW]; // RULE8
    end
  end

  // mode request, held until software writes a new valid code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      requested_mode <= CMM_RST_MODE;
    end else if (wr_ctrl && req_code_ok) begin
      requested_mode <= pwdata[CMM_BIT_REQ_LSB +: 3]; // RULE3
    end
  end

  // reported mode follows only the core's acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_mode <= CMM_RST_MODE; // RULE6
    end else if (mode_ack) begin
      current_mode <= mode_ack_code; // RULE5 RULE16
    end
  end

  // abort request: software sets, core completion clears; a new set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_all_tx <= 1'b0;
    end else if (wr_ctrl && pwdata[CMM_BIT_ABORT]) begin
      abort_all_tx <= 1'b1; // RULE2
    end else if (abort_finish) begin
      abort_all_tx <= 1'b0; // RULE2
    end
  end

  // mask source per filter, two bits each, filter 8 lowest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_mask_select <= CMM_RST_FMSKSEL;
    end else if (wr_fmsk) begin
      filter_mask_select <= pwdata[15:0]; // RULE11 RULE12
    end
  end

  // overflow set and clear terms; a zero written clears, a one keeps
  always_comb begin
    ovf_set = '0;
    if (rx_evt.valid && rx_evt.full) begin
      ovf_set[rx_evt.index] = 1'b1; // RULE13 RULE15
    end
    ovf_clr = '0;
    if (wr_ovf_lo) begin
      ovf_clr[15:0] = ~pwdata[15:0]; // RULE17
    end
    if (wr_ovf_hi) begin
      ovf_clr[31:16] = ~pwdata[15:0]; // RULE15 RULE17
    end
    next_ovf = (rx_overflow & ~ovf_clr) | ovf_set; // RULE14
  end

  // sticky overflow flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overflow <= CMM_RST_OVF; // RULE14
    end else begin
      rx_overflow <= next_ovf;
    end
  end

  // capture event, suppressed while the controller is halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_capture_event <= 1'b0;
    end else begin
      rx_capture_event <= rx_msg_done & rx_capture_enable & ~core_ctl.halt; // RULE7
    end
  end

  // control levels to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctl <= '{halt: 1'b0, abort_req: 1'b0, window_filter: 1'b0, mode_req: CMM_RST_MODE};
    end else begin
      core_ctl.halt <= idle_stop & device_idle; // RULE1
      core_ctl.abort_req <= abort_all_tx; // RULE2
      core_ctl.window_filter <= window_sel; // RULE8
      core_ctl.mode_req <= requested_mode; // RULE3
    end
  end

  // interrupt events
  always_comb begin
    ev_set = '0;
    ev_set[CMM_EV_OVF] = |ovf_set;
    ev_set[CMM_EV_ABORT] = abort_finish;
    ev_set[CMM_EV_MODE] = mode_ack;
    ev_set[CMM_EV_CAPTURE] = rx_msg_done & rx_capture_enable & ~core_ctl.halt;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= CMM_RST_IRQ;
    end else if (wr_istat) begin
      irq_status <= (irq_status & ~pwdata[CMM_EV_COUNT-1:0]) | ev_set;
    end else begin
      irq_status <= irq_status | ev_set;
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= CMM_RST_IRQ;
    end else if (wr_imask) begin
      irq_mask <= pwdata[CMM_EV_COUNT-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read mux; unimplemented and reserved control bits read zero
  always_comb begin
    rd_mux = '0;
    case (paddr)
      CMM_OFS_CTRL: begin
        rd_mux[CMM_BIT_IDLE_STOP] = idle_stop;
        rd_mux[CMM_BIT_ABORT] = abort_all_tx;
        rd_mux[CMM_BIT_REQ_LSB +: 3] = requested_mode;
        rd_mux[CMM_BIT_CUR_LSB +: 3] = current_mode; // RULE5
        rd_mux[CMM_BIT_CAPTURE] = rx_capture_enable;
        rd_mux[CMM_BIT_WINDOW] = window_sel; // RULE9 RULE10
      end
      CMM_OFS_FMSKSEL: begin
        rd_mux[15:0] = filter_mask_select;
      end
      CMM_OFS_OVF_LOW: begin
        rd_mux[15:0] = rx_overflow[15:0];
      end
      CMM_OFS_OVF_HIGH: begin
        rd_mux[15:0] = rx_overflow[31:16]; // RULE15
      end
      CMM_OFS_IRQ_STAT: begin
        rd_mux[CMM_EV_COUNT-1:0] = irq_status;
      end
      CMM_OFS_IRQ_MASK: begin
        rd_mux[CMM_EV_COUNT-1:0] = irq_mask;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  idle_halt_a: assert property ((idle_stop && device_idle) |=> core_ctl.halt) // RULE1
    else $error("halt not raised in idle with idle_stop set");
  idle_run_a: assert property (!idle_stop |=> !core_ctl.halt) // RULE1
    else $error("halt raised with idle_stop clear");
  abort_clear_a: assert property ((abort_finish && !wr_ctrl) |=> !abort_all_tx ##1 // RULE2
    !core_ctl.abort_req)
    else $error("abort bit not cleared after completion");
  abort_hold_a: assert property ((abort_all_tx && !abort_done) |=> abort_all_tx) // RULE2
    else $error("abort bit dropped before completion");
  mode_req_a: assert property ((wr_ctrl && req_code_ok) |=> ##1 // RULE3
    core_ctl.mode_req == $past(pwdata[10:8], 2))
    else $error("requested mode not passed to core");
  mode_rsvd_a: assert property ((wr_ctrl && !req_code_ok) |=> $stable(requested_mode)) // RULE4
    else $error("reserved mode code accepted");
  mode_hold_a: assert property (!mode_ack |=> $stable(current_mode)) // RULE16
    else $error("current mode moved without acknowledge");
  mode_take_a: assert property (mode_ack |=> current_mode == $past(mode_ack_code)) // RULE5
    else $error("current mode not taken from acknowledge");
  capture_on_a: assert property ((rx_msg_done && rx_capture_enable && !core_ctl.halt) // RULE7
    |=> rx_capture_event)
    else $error("capture event missing");
  capture_off_a: assert property (!rx_capture_enable |=> !rx_capture_event) // RULE7
    else $error("capture event while disabled");
  ctrl_zero_a: assert property ((psel && !penable && !pwrite && paddr == CMM_OFS_CTRL) // RULE9
    |=> (prdata[15:14] == 2'h0) && !prdata[11] && !prdata[4] && (prdata[2:1] == 2'h0))
    else $error("unimplemented control bits read nonzero");
  mask_sel_a: assert property (wr_fmsk |=> filter_mask_select == $past(pwdata[15:0])) // RULE11
    else $error("mask select not stored");
  ovf_set_a: assert property ((rx_evt.valid && rx_evt.full) // RULE13
    |=> rx_overflow[$past(rx_evt.index)])
    else $error("overflow flag not set");
  ovf_sticky_a: assert property (!(wr_ovf_lo || wr_ovf_hi) // RULE14
    |=> (($past(rx_overflow) & ~rx_overflow) == 32'h0))
    else $error("overflow flag lost without clear");
  ovf_keep_a: assert property (wr_ovf_lo |=> // RULE17
    ((($past(rx_overflow[15:0]) & $past(pwdata[15:0])) & ~rx_overflow[15:0]) == 16'h0))
    else $error("writing one cleared an overflow flag");
  irq_level_a: assert property ((irq_status & irq_mask) != 4'h0 |-> irq)
    else $error("interrupt output low with pending event");

  mode_chg_c: cover property (wr_ctrl ##[1:20] mode_ack);
  abort_c: cover property (abort_all_tx ##[1:50] !abort_all_tx);
  ovf_clear_c: cover property (rx_overflow[3] ##[1:50] !rx_overflow[3]);
  irq_c: cover property ($rose(irq));

endmodule
`default_nettype wire

//--- design/cmm_pkg.sv
// constants, types and field layout of the can mode/mask/overflow control block
//
// Contract
// [RULE1] idle_stop set halts the controller while the device sits in idle
// [RULE2] abort_all_tx aborts every pending transmit; hardware clears it when all aborted
// [RULE3] requested_mode bits 10-8: 000 normal,001 disable,010 loop,011 listen,100 config,111 all
// [RULE4] software never writes reserved mode codes 101 or 110
// [RULE5] current_mode bits 7-5 is read-only, same encoding as requested_mode
// [RULE6] current_mode reads 100 (configuration) after reset
// [RULE7] rx_capture_enable set makes each received message raise a capture event; the code raises none while core_ctl.halt is set
// [RULE8] window bit 0: one exposes filter registers, zero exposes buffer registers
// [RULE9] control bits 15-14, 4 and 2-1 read as zero
// [RULE10] reserved control bit 11 is not used by software and resets to zero
// [RULE11] mask select register holds two bits per filter, filter 15 at top, 8 at bottom
// [RULE12] mask select code 00/01/10 picks mask 0/1/2; code 11 reserved
// [RULE13] overflow flag n sets on a write attempt into full receive buffer n
// [RULE14] overflow flags reset to zero; hardware only sets, software only clears
// [RULE15] second overflow register holds flags of buffers 31 to 16 in bits 15-0
// [RULE16] current_mode changes only once the controller has really entered the mode
// [RULE17] writing one to an overflow flag keeps it; writing zero clears it
package cmm_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] CMM_OFS_CTRL = 12'h000;
  localparam logic [11:0] CMM_OFS_FMSKSEL = 12'h004;
  localparam logic [11:0] CMM_OFS_OVF_LOW = 12'h008;
  localparam logic [11:0] CMM_OFS_OVF_HIGH = 12'h00c;
  localparam logic [11:0] CMM_OFS_IRQ_STAT = 12'h010;
  localparam logic [11:0] CMM_OFS_IRQ_MASK = 12'h014;

  // control register field positions
  localparam int CMM_BIT_IDLE_STOP = 13;
  localparam int CMM_BIT_ABORT = 12;
  localparam int CMM_BIT_REQ_LSB = 8;
  localparam int CMM_BIT_CUR_LSB = 5;
  localparam int CMM_BIT_CAPTURE = 3;
  localparam int CMM_BIT_WINDOW = 0;

  // operating mode codes
  localparam logic [2:0] CMM_MODE_NORMAL = 3'h0;
  localparam logic [2:0] CMM_MODE_DISABLE = 3'h1;
  localparam logic [2:0] CMM_MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] CMM_MODE_LISTEN = 3'h3;
  localparam logic [2:0] CMM_MODE_CONFIG = 3'h4;
  localparam logic [2:0] CMM_MODE_RSVD_A = 3'h5;
  localparam logic [2:0] CMM_MODE_RSVD_B = 3'h6;
  localparam logic [2:0] CMM_MODE_LISTEN_ALL = 3'h7;

  // reset values
  localparam logic [2:0] CMM_RST_MODE = CMM_MODE_CONFIG;
  localparam logic [15:0] CMM_RST_FMSKSEL = 16'h0000;
  localparam logic [31:0] CMM_RST_OVF = 32'h0000_0000;
  localparam logic [3:0] CMM_RST_IRQ = 4'h0;

  // interrupt event bit positions
  localparam int CMM_EV_OVF = 0;
  localparam int CMM_EV_ABORT = 1;
  localparam int CMM_EV_MODE = 2;
  localparam int CMM_EV_CAPTURE = 3;
  localparam int CMM_EV_COUNT = 4;

  // receive write attempt reported by the controller core
  typedef struct packed {
    logic valid;
    logic full;
    logic [4:0] index;
  } cmm_rx_evt_t;

  // control levels driven to the controller core
  typedef struct packed {
    logic halt;
    logic abort_req;
    logic window_filter;
    logic [2:0] mode_req;
  } cmm_core_ctl_t;

endpackage

//--- tb/cmm_core_model.sv
// core-side model: acknowledges mode requests and transmit aborts
`timescale 1ns/10ps
`default_nettype none
module cmm_core_model
  import cmm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire cmm_core_ctl_t core_ctl,
  output logic abort_done,
  output logic mode_ack,
  output logic [2:0] mode_ack_code
);
  logic [2:0] seen_mode;
  logic [1:0] mode_cnt;
  logic [1:0] abort_cnt;
  logic abort_busy;

  // mode entry takes four cycles; a halted core makes no transition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_mode <= CMM_RST_MODE;
      mode_cnt <= 2'h0;
      mode_ack <= 1'b0;
      mode_ack_code <= CMM_RST_MODE;
    end else begin
      mode_ack <= 1'b0;
      if (core_ctl.mode_req != seen_mode && !core_ctl.halt) begin
        mode_cnt <= mode_cnt + 2'h1;
        if (mode_cnt == 2'h3) begin
          seen_mode <= core_ctl.mode_req;
          mode_ack <= 1'b1;
          mode_ack_code <= core_ctl.mode_req;
        end
      end
    end
  end

  // abort of all transmit buffers finishes four cycles after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_cnt <= 2'h0;
      abort_busy <= 1'b0;
      abort_done <= 1'b0;
    end else begin
      abort_done <= 1'b0;
      if (!core_ctl.abort_req) begin
        abort_busy <= 1'b0;
      end else if (!abort_busy) begin
        abort_cnt <= abort_cnt + 2'h1;
        if (abort_cnt == 2'h3) begin
          abort_done <= 1'b1;
          abort_busy <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/can_mode_mask_overflow_ctl_tb_top.sv
// testbench: apb register checks, core events, overflow flags and interrupt
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t %s", $time, m); end end
module can_mode_mask_overflow_ctl_tb_top;
  import cmm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, device_idle, abort_done, mode_ack;
  logic rx_msg_done, rx_capture_event, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rng, ovf;
  logic [2:0] mode_ack_code, prev;
  logic [4:0] idx;
  logic [15:0] m;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
  cmm_rx_evt_t rx_evt;
  cmm_core_ctl_t core_ctl;
  logic [15:0] filter_mask_select;
  logic [32:0] exp_q [$];
  int n_fail = 0;
  int n_compared = 0;

  always #50 pclk = ~pclk;

  cmm_ctl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_idle(device_idle), .abort_done(abort_done),
    .mode_ack(mode_ack), .mode_ack_code(mode_ack_code), .rx_msg_done(rx_msg_done),
    .rx_evt(rx_evt), .core_ctl(core_ctl), .filter_mask_select(filter_mask_select),
    .rx_capture_event(rx_capture_event), .irq(irq));
  cmm_core_model core (.pclk(pclk), .presetn(presetn), .core_ctl(core_ctl),
    .abort_done(abort_done), .mode_ack(mode_ack), .mode_ack_code(mode_ack_code));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [31:0] ctrl_v(logic idle, logic [2:0] req, logic [2:0] cur,
    logic cap, logic win);
    return {16'h0, 2'h0, idle, 2'h0, req, cur, 1'b0, cap, 2'h0, win};
  endfunction

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // bounded wait for an acknowledge of the core, then let the register load
  task automatic wait_ev(input logic ab);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      if ((ab ? abort_done : mode_ack) === 1'b1) break;
    end
    `CHK(i < 40, 1'b1, "no acknowledge from core")
    repeat (2) @(posedge pclk);
  endtask

  task automatic pulse_rx(input logic full, input logic [4:0] n);
    @(posedge pclk);
    rx_evt <= '{valid: 1'b1, full: full, index: n};
    @(posedge pclk);
    rx_evt <= '0;
  endtask

  task automatic cap_chk(input logic e);
    @(posedge pclk);
    rx_msg_done <= 1'b1;
    @(posedge pclk);
    rx_msg_done <= 1'b0;
    @(posedge pclk);
    `CHK(rx_capture_event, e, "capture event")
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // read checker: oldest expected note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      `CHK({pslverr, prdata}, exp_q.pop_front(), "read data")
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, device_idle, rx_msg_done} = '0;
    paddr = '0;
    pwdata = '0;
    rx_evt = '0;
    rng = 32'h30;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(CMM_OFS_CTRL, ctrl_v(0, CMM_MODE_CONFIG, CMM_MODE_CONFIG, 0, 0), 0);
    rd(CMM_OFS_FMSKSEL, 32'h0, 0);
    rd(CMM_OFS_OVF_LOW, 32'h0, 0);
    rd(CMM_OFS_OVF_HIGH, 32'h0, 0);
    rd(12'h0f0, 32'h0, 1);
    $display("test reset values done");
    prev = CMM_MODE_CONFIG;
    foreach (codes[k]) begin
      wr(CMM_OFS_CTRL, 32'hc016 | (32'(codes[k]) << 8) | 32'(codes[k][0]));
      rd(CMM_OFS_CTRL, ctrl_v(0, codes[k], prev, 0, codes[k][0]), 0);
      wait_ev(1'b0);
      rd(CMM_OFS_CTRL, ctrl_v(0, codes[k], codes[k], 0, codes[k][0]), 0);
      `CHK(core_ctl.mode_req, codes[k], "mode request level")
      `CHK(core_ctl.window_filter, codes[k][0], "window level")
      prev = codes[k];
    end
    for (int r = 5; r < 7; r++) begin
      wr(CMM_OFS_CTRL, 32'(r) << 8);
      rd(CMM_OFS_CTRL, ctrl_v(0, CMM_MODE_CONFIG, CMM_MODE_CONFIG, 0, 0), 0);
    end
    $display("test modes done");
    wr(CMM_OFS_IRQ_STAT, 32'hf);
    wr(CMM_OFS_CTRL, 32'h1400);
    rd(CMM_OFS_CTRL, 32'h1000 | ctrl_v(0, 3'h4, 3'h4, 0, 0), 0);
    `CHK(core_ctl.abort_req, 1'b1, "abort level")
    wait_ev(1'b1);
    rd(CMM_OFS_CTRL, ctrl_v(0, 3'h4, 3'h4, 0, 0), 0);
    rd(CMM_OFS_IRQ_STAT, 32'h2, 0);
    $display("test abort done");
    wr(CMM_OFS_CTRL, ctrl_v(1, 3'h4, 3'h0, 1, 0));
    device_idle <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(core_ctl.halt, 1'b1, "halt in idle")
    cap_chk(1'b0);
    device_idle <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(core_ctl.halt, 1'b0, "halt after idle")
    cap_chk(1'b1);
    wr(CMM_OFS_CTRL, ctrl_v(0, 3'h4, 3'h0, 0, 0));
    cap_chk(1'b0);
    $display("test idle and capture done");
    repeat (3) begin
      m = 16'(xs());
      wr(CMM_OFS_FMSKSEL, {16'h0, m});
      rd(CMM_OFS_FMSKSEL, {16'h0, m}, 0);
      `CHK(filter_mask_select, m, "mask select level")
    end
    $display("test mask select done");
    ovf = 32'h0;
    wr(CMM_OFS_IRQ_MASK, 32'h0);
    wr(CMM_OFS_IRQ_STAT, 32'hf);
    pulse_rx(1'b0, 5'h1f);
    repeat (4) begin
      idx = 5'(xs());
      pulse_rx(1'b1, idx);
      ovf[idx] = 1'b1;
    end
    rd(CMM_OFS_OVF_LOW, {16'h0, ovf[15:0]}, 0);
    rd(CMM_OFS_OVF_HIGH, {16'h0, ovf[31:16]}, 0);
    `CHK(irq, 1'b0, "irq while masked")
    wr(CMM_OFS_IRQ_MASK, 32'h1);
    #1;
    `CHK(irq, 1'b1, "irq unmasked")
    wr(CMM_OFS_OVF_LOW, 32'hffff);
    rd(CMM_OFS_OVF_LOW, {16'h0, ovf[15:0]}, 0);
    wr(CMM_OFS_OVF_LOW, 32'h0);
    wr(CMM_OFS_OVF_HIGH, 32'h0);
    rd(CMM_OFS_OVF_LOW, 32'h0, 0);
    rd(CMM_OFS_OVF_HIGH, 32'h0, 0);
    wr(CMM_OFS_IRQ_STAT, 32'h1);
    #1;
    `CHK(irq, 1'b0, "irq after clear")
    $display("test overflow and irq done");
    test_done();
  end
endmodule
`default_nettype wire
